// File: dv/lhsu_lin_master.sv
// Bus master model: drives break and sync byte onto the receive line
`timescale 1ns/1ps
`default_nettype none

module lhsu_lin_master
(
  input wire logic clk_i,
  output logic lin_o
);
  // Bus has a pull-up, so the idle level is high
  initial lin_o = 1'b1;

  task automatic send_header(input int brk_bits, input int bit_cyc);
    int i;
    @(posedge clk_i);
    lin_o <= 1'b0;
    // Break length is the caller's choice, so short breaks can be tested
    repeat (brk_bits * bit_cyc) @(posedge clk_i);
    lin_o <= 1'b1;
    repeat (bit_cyc) @(posedge clk_i);
    // Sync byte 0x55, LSB first, start and stop bit framed
    for (i = 0; i < 10; i++)
    begin
      lin_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : 1'(8'h55 >> (i - 1));
      repeat (bit_cyc) @(posedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the break and sync timing unit
`timescale 1ns/1ps
`default_nettype none

module testbench
  import lhsu_pkg::*;
;
  localparam int BIT = 16;
  logic clk;
  logic reset_n;
  logic lin;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] v0;
  logic wr;
  logic rd;
  logic irq;
  logic urx;
  int failures;
  int n_checks;

  // Short dividers keep break overflow near 8k cycles
  lhsu_top #(.LP_DIV_P(2), .SYNC_DIV_P(2), .RESET_CYCLES_P(4)) lhsu_top_inst (
    .clk_i(clk), .reset_n_i(reset_n), .ce_i(1'b1), .lin_rx_i(lin), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .uart_rx_o(urx));
  lhsu_lin_master lhsu_lin_master_inst (.clk_i(clk), .lin_o(lin));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd32(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic arm(input logic [31:0] c);
    wr32(ADDR_STATUS, 32'h0000001F);
    wr32(ADDR_CTRL, c | 32'h00000002);
    wr32(ADDR_CTRL, c);
  endtask

  // Probe lands in the sync start bit, before the stop edge ends the header
  task automatic header(input int brk_bits, input logic exp_rx);
    fork
      lhsu_lin_master_inst.send_header(brk_bits, BIT);
      begin
        repeat (BIT * brk_bits + 24) @(posedge clk);
        #1;
        check("uart_rx", 32'(urx), 32'(exp_rx));
      end
    join
    repeat (8) @(posedge clk);
  endtask

  task automatic expect_status(input logic [31:0] exp);
    rd32(ADDR_STATUS, v);
    check("status", v, exp);
  endtask

  task automatic t_reset();
    rd32(ADDR_EDGE, v);
    check("edge_cfg", v, 32'h00000032);
    rd32(ADDR_SYNC, v);
    check("sync", v, 32'h00000000);
    rd32(ADDR_BRK, v);
    check("brk", v, 32'h00000000);
    rd32(32'hFFFF07A0, v);
    check("unmapped", v, 32'h00000000);
    expect_status(32'h00000020);
    check("uart_rx", 32'(urx), 32'h00000001);
    $display("done reset values");
  endtask

  task automatic t_frame();
    wr32(ADDR_MASK, 32'h00000001);
    arm(32'h0000011C);
    header(13, 1'b1);
    expect_status(32'h00000027);
    check("irq", 32'(irq), 32'h00000001);
    rd32(ADDR_SYNC, v);
    check("sync", 32'(v >= 15 && v <= 17), 32'h00000001);
    wr32(ADDR_STATUS, 32'h00000001);
    repeat (2) @(posedge clk);
    #1;
    // Start and stop flags still set but masked
    check("irq", 32'(irq), 32'h00000000);
    $display("done gated frame");
  endtask

  task automatic t_nostart();
    wr32(ADDR_EDGE, 32'h00000062);
    arm(32'h00000014);
    header(13, 1'b0);
    expect_status(32'h00000025);
    rd32(ADDR_SYNC, v);
    check("sync", 32'(v >= 63 && v <= 65), 32'h00000001);
    $display("done five edge frame");
  endtask

  task automatic t_softrst();
    wr32(ADDR_CTRL, 32'h00000015);
    expect_status(32'h00000000);
    repeat (10) @(posedge clk);
    rd32(ADDR_CTRL, v);
    check("ctrl", v, 32'h00000014);
    rd32(ADDR_EDGE, v);
    check("edge_cfg", v, 32'h00000032);
    rd32(ADDR_SYNC, v);
    check("sync", v, 32'h00000000);
    // Eight bits: 64 ticks, below the default compare of 71
    arm(32'h00000014);
    header(8, 1'b0);
    expect_status(32'h00000020);
    rd32(ADDR_SYNC, v);
    check("sync", v, 32'h00000000);
    arm(32'h00000014);
    header(10, 1'b0);
    expect_status(32'h00000025);
    wr32(ADDR_BRK, 32'h00000020);
    arm(32'h00000014);
    header(8, 1'b0);
    expect_status(32'h00000025);
    $display("done soft reset and compare");
  endtask

  task automatic t_disabled();
    rd32(ADDR_SYNC, v0);
    arm(32'h00000000);
    header(13, 1'b0);
    expect_status(32'h00000020);
    rd32(ADDR_SYNC, v);
    check("sync", v, v0);
    $display("done disabled");
  endtask

  task automatic t_brkerr();
    wr32(ADDR_MASK, 32'h00000010);
    arm(32'h00000014);
    fork
      header(700, 1'b0);
      begin
        repeat (1000) @(posedge clk);
        rd32(ADDR_BRK, v);
        check("brk_run", 32'(v > 100), 32'h00000001);
        repeat (10) @(posedge clk);
        rd32(ADDR_BRK, v);
        check("brk_zero", 32'(v <= 8), 32'h00000001);
        repeat (9000) @(posedge clk);
        rd32(ADDR_STATUS, v);
        check("err", v & 32'h00000011, 32'h00000011);
        check("irq", 32'(irq), 32'h00000001);
      end
    join
    $display("done break error");
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Tests need about 15k cycles
  initial
  begin
    #5000000;
    failures++;
    complete_run();
  end

  initial
  begin
    failures = 0;
    n_checks = 0;
    reset_n = 1'b0;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_frame();
    t_nostart();
    t_softrst();
    t_disabled();
    t_brkerr();
    complete_run();
  end
endmodule

`default_nettype wire

// File: src/lhsu_pkg.sv
// Constants, register map and state layout for the break and sync timing block
package lhsu_pkg;

  // Clock and timing figures
  localparam int CLK_HZ = 10_000_000;
  localparam int SYNC_HZ = 5_000_000;
  localparam int LP_HZ = 131_000;
  localparam int RESET_US = 15;
  localparam int SYNC_DIV = CLK_HZ / SYNC_HZ;
  localparam int LP_DIV = CLK_HZ / LP_HZ;
  localparam int RESET_CYCLES = (RESET_US * (CLK_HZ / 1_000_000));
  localparam int DIV_W = 8;

  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'hFFFF0784;
  localparam logic [31:0] ADDR_EDGE = 32'h0FFF078C;
  localparam logic [31:0] ADDR_SYNC = 32'hFFFF0788;
  localparam logic [31:0] ADDR_BRK = 32'hFFFF0790;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFF0794;
  localparam logic [31:0] ADDR_MASK = 32'hFFFF0798;

  // sync_ctrl_primary fields
  localparam int CTRL_W = 9;
  localparam int CTRL_RST = 0;
  localparam int CTRL_ECLR = 1;
  localparam int CTRL_EN = 2;
  localparam int CTRL_START_IE = 3;
  localparam int CTRL_STOP_IE = 4;
  localparam int CTRL_STOP_RISE = 7;
  localparam int CTRL_GATE = 8;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 9'h19F;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // edge_count_config fields
  localparam int EDGE_STOP_LSB = 4;
  localparam int EDGE_START_LSB = 0;
  localparam int EDGE_FLD_W = 4;
  localparam logic [7:0] EDGE_RESET = 8'h32;

  // Break and sync timers
  localparam int BRK_W = 12;
  localparam logic [BRK_W-1:0] BRK_CMP_RESET = 12'h047;
  localparam logic [BRK_W-1:0] BRK_MAX = 12'hFFF;
  localparam int SYNC_W = 16;

  // sync_status fields
  localparam int STA_W = 5;
  localparam int STA_BRK = 0;
  localparam int STA_START = 1;
  localparam int STA_STOP = 2;
  localparam int STA_ERR = 4;
  localparam int STA_READY = 5;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] edge_cfg;
    logic [BRK_W-1:0] brk_cmp;
    logic [BRK_W-1:0] brk_tmr;
    logic [SYNC_W-1:0] sync_tmr;
    logic [STA_W-1:0] status;
    logic [STA_W-1:0] mask;
    logic [EDGE_FLD_W-1:0] fall_cnt;
    logic [EDGE_FLD_W-1:0] rise_cnt;
    logic brk_run;
    logic brk_valid;
    logic sync_run;
    logic hdr_done;
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    logic [DIV_W-1:0] lp_div;
    logic [DIV_W-1:0] sy_div;
    logic [DIV_W-1:0] rst_cnt;
    logic [31:0] rdata;
    logic irq;
    logic uart_rx;
  } lhsu_state_s;

endpackage

// File: src/lhsu_top.sv
// Break and sync byte timing unit for the single wire bus slave
//
// Operation
// - Start interrupt only when start enable set
// - Control bit 2 enables the unit
// - Edge clear bit holds edge counters zero
// - Soft reset bit restores defaults, clears after 15us (mask and the other control bits keep their values)
// - Stop edge count in config bits 7:4
// - Start falling edge count in bits 3:0
// - Break falling edge is edge one
// - Sync timer counts 5 MHz, readable
// - Break timer 12-bit at 131 kHz
// - Falling edge or read zeroes break timer
// - Break location write loads compare register
// - Timer equals compare sets break flag
// - Overflow before rising edge flags break error
// - Compare register resets to 0x47
// - No sync timing without valid break
// - Gate holds UART receive high until header
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lhsu_top
  import lhsu_pkg::*;
#(
  parameter int LP_DIV_P = LP_DIV,
  parameter int SYNC_DIV_P = SYNC_DIV,
  parameter int RESET_CYCLES_P = RESET_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic lin_rx_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic uart_rx_o
);

  initial
  begin
    if (LP_DIV_P < 1 || LP_DIV_P > 255 || SYNC_DIV_P < 1 || SYNC_DIV_P > 255 ||
        RESET_CYCLES_P < 1 || RESET_CYCLES_P > 255)
    begin
      $error("lhsu_top: divider or reset count out of range");
    end
  end

  localparam logic [DIV_W-1:0] LP_TOP = DIV_W'(LP_DIV_P - 1);
  localparam logic [DIV_W-1:0] SY_TOP = DIV_W'(SYNC_DIV_P - 1);
  localparam logic [DIV_W-1:0] RST_TOP = DIV_W'(RESET_CYCLES_P - 1);
  // Must track the parameter, or a shortened reset never reaches the check
  localparam int RST_CHK = RESET_CYCLES_P;

  localparam lhsu_state_s RESET_S = '{
    ctrl: CTRL_RESET, edge_cfg: EDGE_RESET, brk_cmp: BRK_CMP_RESET,
    brk_tmr: '0, sync_tmr: '0, status: '0, mask: '0,
    fall_cnt: '0, rise_cnt: '0, brk_run: 1'b0, brk_valid: 1'b0,
    sync_run: 1'b0, hdr_done: 1'b0, rx_s1: 1'b1, rx_s2: 1'b1, rx_d: 1'b1,
    lp_div: '0, sy_div: '0, rst_cnt: '0, rdata: '0, irq: 1'b0, uart_rx: 1'b1
  };

  // Free-running divider step, wraps at top
  function automatic logic [DIV_W-1:0] wrap_inc(input logic [DIV_W-1:0] v,
                                                 input logic [DIV_W-1:0] top);
    wrap_inc = (v == top) ? '0 : DIV_W'(v + 1'b1);
  endfunction

  // Saturating edge counter step
  function automatic logic [EDGE_FLD_W-1:0] sat_inc(input logic [EDGE_FLD_W-1:0] v);
    sat_inc = (&v) ? v : EDGE_FLD_W'(v + 1'b1);
  endfunction

  lhsu_state_s s_reg;
  lhsu_state_s s_next;

  logic fall;
  logic rise;
  logic en;
  logic lp_tick;
  logic sy_tick;
  logic [EDGE_FLD_W-1:0] fall_new;
  logic [EDGE_FLD_W-1:0] rise_new;
  logic [EDGE_FLD_W-1:0] start_cnt;
  logic [EDGE_FLD_W-1:0] stop_cnt;
  logic [STA_W-1:0] set_v;
  logic [STA_W-1:0] clr_v;
  logic stop_hit;

  always_comb
  begin
    s_next = s_reg;
    fall = s_reg.rx_d & ~s_reg.rx_s2;
    rise = ~s_reg.rx_d & s_reg.rx_s2;
    en = s_reg.ctrl[CTRL_EN] & ~s_reg.ctrl[CTRL_RST];
    lp_tick = (s_reg.lp_div == LP_TOP);
    sy_tick = (s_reg.sy_div == SY_TOP);
    fall_new = sat_inc(s_reg.fall_cnt);
    rise_new = sat_inc(s_reg.rise_cnt);
    start_cnt = s_reg.edge_cfg[EDGE_START_LSB +: EDGE_FLD_W];
    stop_cnt = s_reg.edge_cfg[EDGE_STOP_LSB +: EDGE_FLD_W];
    set_v = '0;
    clr_v = '0;
    stop_hit = 1'b0;
    if (ce_i)
    begin
      s_next.rdata = '0;
      // Pin passes two flops before edge detection; the UART receive gate reads it after the same two (rx_s2)
      s_next.rx_s1 = lin_rx_i;
      s_next.rx_s2 = s_reg.rx_s1;
      s_next.rx_d = s_reg.rx_s2;
      s_next.lp_div = wrap_inc(s_reg.lp_div, LP_TOP);
      s_next.sy_div = wrap_inc(s_reg.sy_div, SY_TOP);
      // Disabled unit freezes timers and flags
      if (en)
      begin
        if (fall)
        begin
          s_next.fall_cnt = fall_new;
          s_next.brk_tmr = '0;
          if (s_reg.fall_cnt == '0)
          begin
            s_next.brk_run = 1'b1;
            s_next.brk_valid = 1'b0;
            s_next.hdr_done = 1'b0;
          end
        end
        if (rise)
        begin
          s_next.rise_cnt = rise_new;
          s_next.brk_run = 1'b0;
        end
        if (s_reg.sync_run)
        begin
          stop_hit = s_reg.ctrl[CTRL_STOP_RISE] ? (rise && rise_new == stop_cnt)
                                                : (fall && fall_new == stop_cnt);
          if (stop_hit)
          begin
            s_next.sync_run = 1'b0;
            s_next.hdr_done = 1'b1;
            set_v[STA_STOP] = s_reg.ctrl[CTRL_STOP_IE];
          end
          else if (sy_tick)
          begin
            s_next.sync_tmr = SYNC_W'(s_reg.sync_tmr + 1'b1);
          end
        end
        else if (fall && s_reg.brk_valid && !s_reg.hdr_done && fall_new == start_cnt)
        begin
          // A missed break leaves the sync timer idle
          s_next.sync_run = 1'b1;
          s_next.sync_tmr = '0;
          set_v[STA_START] = s_reg.ctrl[CTRL_START_IE];
        end
        if (s_reg.brk_run && lp_tick && !fall && !rise)
        begin
          if (s_reg.brk_tmr == BRK_MAX)
          begin
            set_v[STA_ERR] = 1'b1;
            s_next.brk_run = 1'b0;
          end
          else
          begin
            s_next.brk_tmr = BRK_W'(s_reg.brk_tmr + 1'b1);
            if (BRK_W'(s_reg.brk_tmr + 1'b1) == s_reg.brk_cmp)
            begin
              set_v[STA_BRK] = 1'b1;
              s_next.brk_valid = 1'b1;
            end
          end
        end
      end
      if (s_reg.ctrl[CTRL_ECLR])
      begin
        s_next.fall_cnt = '0;
        s_next.rise_cnt = '0;
      end
      if (wr_i)
      begin
        case (addr_i)
          ADDR_CTRL:
          begin
            s_next.ctrl = wdata_i[CTRL_W-1:0] & CTRL_WMASK;
            s_next.rst_cnt = '0;
          end
          ADDR_EDGE: s_next.edge_cfg = wdata_i[7:0];
          ADDR_BRK: s_next.brk_cmp = wdata_i[BRK_W-1:0];
          ADDR_STATUS: clr_v = wdata_i[STA_W-1:0];
          ADDR_MASK: s_next.mask = wdata_i[STA_W-1:0];
          default:
          begin
          end
        endcase
      end
      if (rd_i)
      begin
        case (addr_i)
          ADDR_CTRL: s_next.rdata = 32'(s_reg.ctrl);
          ADDR_EDGE: s_next.rdata = 32'(s_reg.edge_cfg);
          ADDR_SYNC: s_next.rdata = 32'(s_reg.sync_tmr);
          ADDR_BRK:
          begin
            s_next.rdata = 32'(s_reg.brk_tmr);
            s_next.brk_tmr = '0;
          end
          ADDR_STATUS:
            s_next.rdata = 32'({~s_reg.ctrl[CTRL_RST], s_reg.status});
          ADDR_MASK: s_next.rdata = 32'(s_reg.mask);
          default: s_next.rdata = '0;
        endcase
      end
      // Set beats a clear landing in the same cycle
      s_next.status = (s_reg.status & ~clr_v) | set_v;
      if (s_reg.ctrl[CTRL_RST])
      begin
        s_next.edge_cfg = EDGE_RESET;
        s_next.brk_cmp = BRK_CMP_RESET;
        s_next.brk_tmr = '0;
        s_next.sync_tmr = '0;
        s_next.status = '0;
        s_next.fall_cnt = '0;
        s_next.rise_cnt = '0;
        s_next.brk_run = 1'b0;
        s_next.brk_valid = 1'b0;
        s_next.sync_run = 1'b0;
        s_next.hdr_done = 1'b0;
        if (!(wr_i && addr_i == ADDR_CTRL))
        begin
          s_next.rst_cnt = DIV_W'(s_reg.rst_cnt + 1'b1);
          if (s_reg.rst_cnt == RST_TOP)
          begin
            s_next.ctrl[CTRL_RST] = 1'b0;
          end
        end
      end
      s_next.irq = |(s_next.status & s_next.mask);
      // Receive line forced idle while header is pending
      s_next.uart_rx = (s_next.ctrl[CTRL_GATE] & ~s_next.hdr_done) | s_next.rx_s2;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s_reg <= RESET_S;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign irq_o = s_reg.irq;
  assign uart_rx_o = s_reg.uart_rx;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_start_irq_gate:
    assert property ($rose(s_reg.status[STA_START]) |-> s_reg.ctrl[CTRL_START_IE])
    else $error("start flag set with start enable clear");

  chk_disabled_hold:
    assert property (ce_i && !s_reg.ctrl[CTRL_EN] && !s_reg.ctrl[CTRL_RST]
                     && !(wr_i && addr_i == ADDR_CTRL)
                     |=> $stable(s_reg.sync_tmr) && !s_next.status[STA_BRK] ||
                         $past(s_reg.status[STA_BRK]))
    else $error("sync timer moved while unit disabled");

  chk_edge_clear_hold:
    assert property (ce_i && s_reg.ctrl[CTRL_ECLR] && !(wr_i && addr_i == ADDR_CTRL)
                     |=> s_reg.fall_cnt == '0 && s_reg.rise_cnt == '0 && s_reg.ctrl[CTRL_ECLR])
    else $error("edge counters not held clear");

  chk_reset_self_clear:
    assert property (ce_i && s_reg.ctrl[CTRL_RST] && s_reg.rst_cnt == DIV_W'(RST_CHK - 1)
                     && !wr_i |=> !s_reg.ctrl[CTRL_RST] && s_reg.brk_cmp == BRK_CMP_RESET)
    else $error("soft reset bit did not clear on time");

  chk_brk_read_zero:
    assert property (ce_i && rd_i && addr_i == ADDR_BRK && !s_reg.ctrl[CTRL_RST]
                     |=> s_reg.brk_tmr == '0 && rdata_o == 32'($past(s_reg.brk_tmr)))
    else $error("break read did not return and zero the timer");

  chk_brk_write_cmp:
    assert property (ce_i && wr_i && addr_i == ADDR_BRK && !s_reg.ctrl[CTRL_RST]
                     |=> s_reg.brk_cmp == $past(wdata_i[BRK_W-1:0]))
    else $error("compare register not loaded");

  chk_cmp_flag:
    assert property ($rose(s_reg.status[STA_BRK]) |-> s_reg.brk_tmr == s_reg.brk_cmp
                     && s_reg.brk_valid)
    else $error("break flag without compare match");

  chk_sync_needs_brk:
    assert property ($rose(s_reg.sync_run) |-> $past(s_reg.brk_valid))
    else $error("sync timing began without a valid break");

  chk_uart_gated:
    assert property (s_reg.ctrl[CTRL_GATE] && !s_reg.hdr_done |-> uart_rx_o)
    else $error("receive line not gated during header");

  chk_irq_level:
    assert property (ce_i |=> irq_o == |(s_reg.status & s_reg.mask))
    else $error("interrupt output does not follow status and mask");

endmodule

`default_nettype wire
